// File: hw/fprs_pkg.sv
// Constants for the floppy controller drive-poll and result-status block.
// Assumes a 10 MHz reference clock and the data-rate select codes listed below.
package fprs_pkg;

  // Clock and timing.
  localparam int CLK_KHZ = 10000;
  localparam int POLL_TIME_US = 1000;
  localparam int POLL_CYCLES = (POLL_TIME_US * CLK_KHZ) / 1000;
  localparam int PDN_WAIT_MS = 512;
  localparam int PDN_WAIT_CYCLES = PDN_WAIT_MS * CLK_KHZ;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_CYCLES = (STEP_PULSE_NS * CLK_KHZ + 999999) / 1000000;

  // Data-rate select codes and their weights in units of 50 Kbps.
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [4:0] WEIGHT_500K = 5'h0a;
  localparam logic [4:0] WEIGHT_300K = 5'h06;
  localparam logic [4:0] WEIGHT_250K = 5'h05;
  localparam logic [4:0] WEIGHT_1M = 5'h14;
  localparam int WEIGHT_REF = 10;

  // Data port offsets.
  localparam logic [2:0] MAIN_STATE_OFFSET = 3'h4;
  localparam logic [2:0] DATA_PORT_OFFSET = 3'h5;

  // Interrupt reason codes in the first status byte.
  localparam logic [1:0] REASON_NORMAL = 2'h0;
  localparam logic [1:0] REASON_ABNORMAL = 2'h1;
  localparam logic [1:0] REASON_INVALID = 2'h2;
  localparam logic [1:0] REASON_READY_CHG = 2'h3;

  // Field positions in the first status byte.
  localparam int FIRST_SIDE_BIT = 2;
  localparam int FIRST_EQUIP_BIT = 4;
  localparam int FIRST_SEEK_END_BIT = 5;
  // Field positions in the second status byte.
  localparam int SECOND_MISS_AM_BIT = 0;
  localparam int SECOND_WLOCK_BIT = 1;
  localparam int SECOND_NO_DATA_BIT = 2;
  localparam int SECOND_OVERRUN_BIT = 4;
  localparam int SECOND_CRC_BIT = 5;
  localparam int SECOND_EOT_BIT = 7;
  // Field positions in the third status byte.
  localparam int THIRD_AM_LOC_BIT = 0;
  localparam int THIRD_BAD_TRACK_BIT = 1;
  localparam int THIRD_SCAN_NOT_BIT = 2;
  localparam int THIRD_SCAN_HIT_BIT = 3;
  localparam int THIRD_WRONG_TRACK_BIT = 4;
  localparam int THIRD_CRC_DATA_BIT = 5;
  localparam int THIRD_CTRL_MARK_BIT = 6;

  // Main state register bit positions.
  localparam int MAIN_BUSY_BIT = 4;
  localparam int MAIN_DIO_BIT = 6;
  localparam int MAIN_RQM_BIT = 7;

  // Result lengths and reset values.
  localparam logic [1:0] LEN_TERM = 2'h3;
  localparam logic [1:0] LEN_SENSE = 2'h1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] INVALID_STATUS = 8'h80;

endpackage

// File: hw/fprs_poll_tick.sv
// Rate-scaled tick that starts each drive-poll phase.
// Assumes the rate select is a stable level from the same clock domain.
`timescale 1ns/10ps
module fprs_poll_tick #(
  parameter int POLL_CYCLES = fprs_pkg::POLL_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] data_rate_i,
  output logic tick_o
);

  // The accumulator adds the rate in 50 Kbps units, so every rate but 300 Kbps gets an exact period.
  localparam logic [23:0] THRESH = 24'(POLL_CYCLES * fprs_pkg::WEIGHT_REF);

  typedef struct packed {
    logic [23:0] acc;
    logic tick;
  } fprs_tick_state_type;

  fprs_tick_state_type state_reg;
  fprs_tick_state_type state_next;

  always_comb begin
    logic [4:0] weight;
    logic [23:0] sum;
    weight = fprs_pkg::WEIGHT_500K;
    sum = 24'h000000;
    state_next = state_reg;
    unique case (data_rate_i)
      fprs_pkg::RATE_500K: weight = fprs_pkg::WEIGHT_500K;
      fprs_pkg::RATE_300K: weight = fprs_pkg::WEIGHT_300K;
      fprs_pkg::RATE_250K: weight = fprs_pkg::WEIGHT_250K;
      fprs_pkg::RATE_1M: weight = fprs_pkg::WEIGHT_1M;
    endcase
    sum = state_reg.acc + {19'h00000, weight};
    state_next.tick = 1'b0;
    if (sum >= THRESH) begin
      state_next.acc = sum - THRESH;
      state_next.tick = 1'b1;
    end else begin
      state_next.acc = sum;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_o = state_reg.tick;

endmodule

// File: hw/fprs_core.sv
// Drive-poll phase, head stepping, delayed power-down and result status bytes.
// Assumes all inputs come from controller logic on ref_clk_i; drive pins are
// synchronised there. Reset is the hardware or software reset of the unit.
`timescale 1ns/10ps
// How it works
// - Poll every 1 ms at 500 Kbps, rate-scaled
// - Toggle ready lines after reset, interrupt drive 0
// - Stepping and power-down run even unpolled
// - Wait 512 ms after motor-off before power-down
// - Withhold parameter ready until poll loop ends
// - Status bytes only in result phase
// - First byte holds drive and side
// - Unused status bits read zero
// - Homing without home track sets bit 4
// - Positioning commands completed set bit 5
// - Bits 7:6 carry interrupt reason
// - Missing mark flag and its location
// - Write-lock flag for write and format
// - Missing data flag, three cases
// - Overrun or underrun flag
// - CRC flag and field location
// - End of track without transfer-count end
// - Wrong track and bad track flags
// - Scan hit and scan not satisfied
// - Control mark flag
module fprs_core #(
  parameter int POLL_CYCLES = fprs_pkg::POLL_CYCLES,
  parameter int PDN_WAIT_CYCLES = fprs_pkg::PDN_WAIT_CYCLES,
  parameter int STEP_CYCLES = fprs_pkg::STEP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] data_rate_i,
  input wire logic idle_i,
  input wire logic poll_disable_i,
  input wire logic cmd_start_i,
  input wire logic [3:0] step_req_i,
  input wire logic [3:0] step_dir_i,
  input wire logic auto_pd_en_i,
  input wire logic motor_off_expired_i,
  input wire logic sense_int_i,
  input wire logic term_i,
  input wire logic [1:0] interrupt_reason_i,
  input wire logic [1:0] drive_sel_i,
  input wire logic side_select_out_i,
  input wire logic head_homing_cmd_i,
  input wire logic positioning_cmd_i,
  input wire logic home_track_in_i,
  input wire logic missing_am_i,
  input wire logic am_in_data_i,
  input wire logic write_cmd_i,
  input wire logic write_lock_i,
  input wire logic no_data_i,
  input wire logic overrun_i,
  input wire logic crc_err_i,
  input wire logic crc_in_data_i,
  input wire logic eot_no_tc_i,
  input wire logic wrong_track_i,
  input wire logic track_is_ff_i,
  input wire logic scan_hit_i,
  input wire logic scan_not_i,
  input wire logic control_mark_i,
  input wire logic port_rd_i,
  input wire logic [2:0] port_addr_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic result_phase_o,
  output logic irq_o,
  output logic poll_active_o,
  output logic param_hold_o,
  output logic [3:0] drive_ready_o,
  output logic step_o,
  output logic dir_o,
  output logic [3:0] step_ack_o,
  output logic power_down_o
);

  typedef enum logic [3:0] {
    FPRS_IDLE = 4'h1,
    FPRS_POLL = 4'h2,
    FPRS_DIR = 4'h4,
    FPRS_STEP = 4'h8
  } fprs_fsm_type;

  typedef struct packed {
    fprs_fsm_type fsm;
    logic [1:0] drv;
    logic [7:0] step_cnt;
    logic [3:0] ready;
    logic [3:0] chg;
    logic after_reset;
    logic hold;
    logic pd_armed;
    logic [23:0] pd_cnt;
    logic power_down;
    logic step;
    logic dir;
    logic [3:0] step_ack;
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] third;
    logic res_phase;
    logic [1:0] res_idx;
    logic [1:0] res_len;
    logic [7:0] rd_data;
    logic rd_valid;
    logic irq;
    logic poll_active;
  } fprs_state_type;
  localparam logic [23:0] PDN_LAST = 24'(PDN_WAIT_CYCLES - 1);
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);
  fprs_state_type state_reg;
  fprs_state_type state_next;
  logic poll_tick;

  fprs_poll_tick #(
    .POLL_CYCLES(POLL_CYCLES)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .data_rate_i(data_rate_i),
    .tick_o(poll_tick)
  );

  always_comb begin
    logic last_drive;
    logic found;
    logic [1:0] sense_drv;
    last_drive = (state_reg.drv == 2'h3);
    found = 1'b0;
    sense_drv = 2'h0;
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    state_next.step_ack = 4'h0;
    state_next.hold = state_reg.hold && state_reg.fsm != FPRS_IDLE;
    unique case (state_reg.fsm)
      FPRS_IDLE: begin
        if (poll_tick && idle_i) begin
          state_next.fsm = FPRS_POLL;
          state_next.drv = 2'h0;
        end
      end
      FPRS_POLL: begin
        if (state_reg.after_reset && !poll_disable_i) begin
          state_next.ready[state_reg.drv] = ~state_reg.ready[state_reg.drv];
          state_next.chg[state_reg.drv] = 1'b1;
        end
        if (auto_pd_en_i && motor_off_expired_i) begin
          state_next.pd_armed = 1'b1;
        end
        if (step_req_i[state_reg.drv]) begin
          state_next.dir = step_dir_i[state_reg.drv];
          state_next.fsm = FPRS_DIR;
        end else if (last_drive) begin
          state_next.fsm = FPRS_IDLE;
        end else begin
          state_next.drv = state_reg.drv + 2'h1;
        end
      end
      FPRS_DIR: begin
        // The direction level settles one cycle before the step pulse rises.
        state_next.step = 1'b1;
        state_next.step_cnt = 8'h00;
        state_next.fsm = FPRS_STEP;
      end
      FPRS_STEP: begin
        if (state_reg.step_cnt == STEP_LAST) begin
          state_next.step = 1'b0;
          state_next.step_ack[state_reg.drv] = 1'b1;
          if (last_drive) begin
            state_next.fsm = FPRS_IDLE;
          end else begin
            state_next.drv = state_reg.drv + 2'h1;
            state_next.fsm = FPRS_POLL;
          end
        end else begin
          state_next.step_cnt = state_reg.step_cnt + 8'h01;
        end
      end
    endcase
    state_next.poll_active = state_next.fsm != FPRS_IDLE;
    // End of one whole poll loop.
    if (state_reg.fsm != FPRS_IDLE && state_next.fsm == FPRS_IDLE) begin
      state_next.after_reset = 1'b0;
      state_next.hold = 1'b0;
    end
    if (cmd_start_i && state_reg.fsm != FPRS_IDLE) begin
      state_next.hold = 1'b1;
    end
    if (!(auto_pd_en_i && motor_off_expired_i) || cmd_start_i) begin
      state_next.pd_armed = 1'b0;
      state_next.pd_cnt = 24'h000000;
      state_next.power_down = 1'b0;
    end else if (state_reg.pd_armed) begin
      if (state_reg.pd_cnt == PDN_LAST) begin
        state_next.power_down = 1'b1;
      end else begin
        state_next.pd_cnt = state_reg.pd_cnt + 24'h000001;
      end
    end

    if (term_i && !state_reg.res_phase) begin
      state_next.res_phase = 1'b1;
      state_next.res_idx = 2'h0;
      state_next.res_len = fprs_pkg::LEN_TERM;
      state_next.irq = 1'b1;
      state_next.first = fprs_pkg::STATUS_RESET;
      state_next.second = fprs_pkg::STATUS_RESET;
      state_next.third = fprs_pkg::STATUS_RESET;
      if (interrupt_reason_i == fprs_pkg::REASON_INVALID) begin
        state_next.first = fprs_pkg::INVALID_STATUS;
      end else begin
        state_next.first[7:6] = interrupt_reason_i;
        state_next.first[1:0] = drive_sel_i;
        state_next.first[fprs_pkg::FIRST_SIDE_BIT] = side_select_out_i;
        state_next.first[fprs_pkg::FIRST_EQUIP_BIT] = head_homing_cmd_i && !home_track_in_i;
        state_next.first[fprs_pkg::FIRST_SEEK_END_BIT] = positioning_cmd_i;
        state_next.second[fprs_pkg::SECOND_MISS_AM_BIT] = missing_am_i;
        state_next.third[fprs_pkg::THIRD_AM_LOC_BIT] = missing_am_i && am_in_data_i;
        state_next.second[fprs_pkg::SECOND_WLOCK_BIT] = write_cmd_i && write_lock_i;
        state_next.second[fprs_pkg::SECOND_NO_DATA_BIT] = no_data_i;
        state_next.second[fprs_pkg::SECOND_OVERRUN_BIT] = overrun_i;
        state_next.second[fprs_pkg::SECOND_CRC_BIT] = crc_err_i;
        state_next.third[fprs_pkg::THIRD_CRC_DATA_BIT] = crc_err_i && crc_in_data_i;
        state_next.second[fprs_pkg::SECOND_EOT_BIT] = eot_no_tc_i;
        state_next.third[fprs_pkg::THIRD_WRONG_TRACK_BIT] = wrong_track_i;
        state_next.third[fprs_pkg::THIRD_BAD_TRACK_BIT] = wrong_track_i && track_is_ff_i;
        state_next.third[fprs_pkg::THIRD_SCAN_HIT_BIT] = scan_hit_i;
        state_next.third[fprs_pkg::THIRD_SCAN_NOT_BIT] = scan_not_i;
        state_next.third[fprs_pkg::THIRD_CTRL_MARK_BIT] = control_mark_i;
      end
    end else if (sense_int_i && !state_reg.res_phase) begin
      for (int i = 3; i >= 0; i--) begin
        if (state_reg.chg[i]) begin
          found = 1'b1;
          sense_drv = 2'(i);
        end
      end
      state_next.res_phase = 1'b1;
      state_next.res_idx = 2'h0;
      state_next.res_len = fprs_pkg::LEN_SENSE;
      if (found) begin
        state_next.first = {fprs_pkg::REASON_READY_CHG, 4'h0, sense_drv};
        state_next.chg[sense_drv] = 1'b0;
        // A set from the poll loop in this same cycle must survive the clear.
        if (state_reg.fsm == FPRS_POLL && state_reg.drv == sense_drv &&
            state_reg.after_reset && !poll_disable_i) begin
          state_next.chg[sense_drv] = 1'b1;
        end
        if (state_reg.chg == (4'h1 << sense_drv)) begin
          state_next.irq = 1'b0;
        end
      end else begin
        state_next.first = fprs_pkg::INVALID_STATUS;
      end
    end

    // data port and main state reads
    if (port_rd_i) begin
      state_next.rd_valid = 1'b1;
      state_next.rd_data = 8'h00;
      if (port_addr_i == fprs_pkg::MAIN_STATE_OFFSET) begin
        state_next.rd_data[3:0] = state_reg.chg;
        state_next.rd_data[fprs_pkg::MAIN_BUSY_BIT] = state_reg.res_phase;
        state_next.rd_data[fprs_pkg::MAIN_DIO_BIT] = state_reg.res_phase;
        state_next.rd_data[fprs_pkg::MAIN_RQM_BIT] = !state_reg.hold;
      end else if (port_addr_i == fprs_pkg::DATA_PORT_OFFSET && state_reg.res_phase) begin
        unique case (state_reg.res_idx)
          2'h0: state_next.rd_data = state_reg.first;
          2'h1: state_next.rd_data = state_reg.second;
          default: state_next.rd_data = state_reg.third;
        endcase
        if (state_reg.res_idx == 2'h0) begin
          state_next.irq = 1'b0;
        end
        if (state_reg.res_idx == state_reg.res_len - 2'h1) begin
          state_next.res_phase = 1'b0;
        end else begin
          state_next.res_idx = state_reg.res_idx + 2'h1;
        end
      end
    end
    // interrupt for drive 0; this set wins over the read and query clears.
    if (state_reg.fsm != FPRS_IDLE && state_next.fsm == FPRS_IDLE && state_reg.after_reset &&
        !poll_disable_i) begin
      state_next.irq = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= '0;
      state_reg.fsm <= FPRS_IDLE;
      state_reg.after_reset <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_o = state_reg.rd_data;
  assign rd_valid_o = state_reg.rd_valid;
  assign result_phase_o = state_reg.res_phase;
  assign irq_o = state_reg.irq;
  assign poll_active_o = state_reg.poll_active;
  assign param_hold_o = state_reg.hold;
  assign drive_ready_o = state_reg.ready;
  assign step_o = state_reg.step;
  assign dir_o = state_reg.dir;
  assign step_ack_o = state_reg.step_ack;
  assign power_down_o = state_reg.power_down;

endmodule

// File: bench/fprs_core_chk.sv
// Concurrent checks on the ports of the drive-poll and result-status core.
// Assumes it is bound into fprs_core with the core's count parameters handed on.
`timescale 1ns/10ps
module fprs_core_chk #(
  parameter int PDN_WAIT_CYCLES = fprs_pkg::PDN_WAIT_CYCLES,
  parameter int STEP_CYCLES = fprs_pkg::STEP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic port_rd_i,
  input wire logic [2:0] port_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic result_phase_o,
  input wire logic irq_o,
  input wire logic term_i,
  input wire logic cmd_start_i,
  input wire logic poll_active_o,
  input wire logic param_hold_o,
  input wire logic step_o,
  input wire logic [3:0] step_ack_o,
  input wire logic auto_pd_en_i,
  input wire logic motor_off_expired_i,
  input wire logic power_down_o
);
  int step_cnt;
  int pd_cnt;

  // Counters let long spans be checked without unrolled repetitions.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      step_cnt <= 0;
      pd_cnt <= 0;
    end else begin
      step_cnt <= step_o ? step_cnt + 1 : 0;
      pd_cnt <= (auto_pd_en_i && motor_off_expired_i && !cmd_start_i) ? pd_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_read_answer: assert property (port_rd_i |=> rd_valid_o)
    else $error("read strobe got no answer");
  chk_closed_port: assert property (port_rd_i && port_addr_i == 3'h5 && !result_phase_o
    |=> rd_data_o == 8'h00) else $error("status readable outside result phase");
  chk_term_opens: assert property (term_i && !result_phase_o
    |=> result_phase_o && irq_o) else $error("termination did not open result phase");
  chk_first_spare: assert property (port_rd_i && port_addr_i == 3'h5 && result_phase_o
    && irq_o |=> !rd_data_o[3]) else $error("unused first byte bit set");
  chk_hold_on_cmd: assert property (cmd_start_i && poll_active_o |=> param_hold_o)
    else $error("command during poll not held");
  chk_hold_release: assert property (param_hold_o && !poll_active_o
    |=> !param_hold_o) else $error("hold outlived poll loop");
  chk_step_width: assert property ($fell(step_o) |-> step_cnt == STEP_CYCLES)
    else $error("step pulse width wrong");
  chk_step_ack: assert property ($fell(step_o) |-> ##[0:1] $onehot(step_ack_o))
    else $error("step not acknowledged");
  chk_pdn_wait: assert property ($rose(power_down_o) |-> pd_cnt >= PDN_WAIT_CYCLES)
    else $error("power-down came early");
  chk_pdn_drop: assert property (!auto_pd_en_i || !motor_off_expired_i
    |=> !power_down_o) else $error("power-down held without cause");

  cover property (term_i && !result_phase_o);
  cover property ($fell(step_o));
  cover property ($rose(power_down_o));
  cover property (cmd_start_i && poll_active_o);
endmodule

// File: bench/fprs_host.sv
// Host software model: reads the data and main state ports and issues queries.
// Assumes the bench clock; read_port and sense_query change their outputs only at falling edges.
`timescale 1ns/10ps
module fprs_host (
  input wire logic ref_clk_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  output logic port_rd_i,
  output logic [2:0] port_addr_i,
  output logic sense_int_i,
  output logic poll_disable_i
);
  initial begin
    port_rd_i = 1'b0;
    port_addr_i = 3'h0;
    sense_int_i = 1'b0;
    poll_disable_i = 1'b0;
  end

  task automatic read_port(input logic [2:0] addr, output logic [7:0] data);
    int n;
    @(negedge ref_clk_i);
    port_rd_i = 1'b1;
    port_addr_i = addr;
    @(negedge ref_clk_i);
    port_rd_i = 1'b0;
    for (n = 0; n < 3 && rd_valid_o !== 1'b1; n++) @(negedge ref_clk_i);
    data = rd_data_o;
  endtask

  task automatic sense_query(output logic [7:0] data);
    @(negedge ref_clk_i);
    sense_int_i = 1'b1;
    @(negedge ref_clk_i);
    sense_int_i = 1'b0;
    read_port(fprs_pkg::DATA_PORT_OFFSET, data);
  endtask

  task automatic set_poll_disable(input logic v);
    poll_disable_i = v;
  endtask
endmodule

// File: bench/test_fprs_poll_and_result_status.sv
// Self-checking bench for the drive-poll and result-status core.
// Assumes fprs_pkg, fprs_core, the host model and the checker are compiled first.
`timescale 1ns/10ps
module test_fprs_poll_and_result_status;
  localparam int POLL_CYCLES = 40;
  localparam int PDN_WAIT_CYCLES = 100;
  localparam int STEP_CYCLES = 2;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic idle_i = 1'b0;
  logic cmd_start_i = 1'b0;
  logic auto_pd_en_i = 1'b0;
  logic motor_off_expired_i = 1'b0;
  logic term_i = 1'b0;
  logic [1:0] data_rate_i = 2'h0;
  logic [1:0] interrupt_reason_i = 2'h0;
  logic [1:0] drive_sel_i = 2'h0;
  logic [3:0] step_req_i = 4'h0;
  logic [3:0] step_dir_i = 4'h0;
  logic [17:0] f = 18'h0;
  logic poll_disable_i, sense_int_i, port_rd_i, rd_valid_o, result_phase_o, irq_o;
  logic poll_active_o, param_hold_o, step_o, dir_o, power_down_o;
  logic [2:0] port_addr_i;
  logic [7:0] rd_data_o, rd;
  logic [3:0] drive_ready_o, step_ack_o;
  logic [31:0] seed = 32'h3ca7c69c;
  logic [31:0] r;
  int n_errors = 0;
  int samples_checked = 0;
  int n, g;
  int exp_q[$];
  logic [1:0] rates [3] = '{fprs_pkg::RATE_500K, fprs_pkg::RATE_250K, fprs_pkg::RATE_1M};
  int gaps [3] = '{POLL_CYCLES, POLL_CYCLES * 2, POLL_CYCLES / 2};

  fprs_core #(.POLL_CYCLES(POLL_CYCLES), .PDN_WAIT_CYCLES(PDN_WAIT_CYCLES),
    .STEP_CYCLES(STEP_CYCLES)) i_fprs_core (.*, .side_select_out_i(f[0]),
    .head_homing_cmd_i(f[1]), .positioning_cmd_i(f[2]), .home_track_in_i(f[3]),
    .missing_am_i(f[4]), .am_in_data_i(f[5]), .write_cmd_i(f[6]), .write_lock_i(f[7]),
    .no_data_i(f[8]), .overrun_i(f[9]), .crc_err_i(f[10]), .crc_in_data_i(f[11]),
    .eot_no_tc_i(f[12]), .wrong_track_i(f[13]), .track_is_ff_i(f[14]),
    .scan_hit_i(f[15]), .scan_not_i(f[16]), .control_mark_i(f[17]));
  fprs_host i_fprs_host (.*);

  always #50 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("%0d values checked, %0d wrong", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Waits for the end of the current poll loop and the start of the next one.
  task automatic next_poll(output int waited);
    waited = 0;
    while (poll_active_o === 1'b1 && waited < 400) begin
      @(negedge ref_clk_i);
      waited++;
    end
    while (poll_active_o !== 1'b1 && waited < 400) begin
      @(negedge ref_clk_i);
      waited++;
    end
  endtask

  // Expected status bytes, worked out from the inputs present at termination.
  function automatic void model();
    int a, b, c;
    a = interrupt_reason_i * 64 + f[2] * 32 + (f[1] & ~f[3]) * 16 + f[0] * 4 + drive_sel_i;
    b = f[12] * 128 + f[10] * 32 + f[9] * 16 + f[8] * 4 + (f[6] & f[7]) * 2 + f[4];
    c = f[17] * 64 + (f[10] & f[11]) * 32 + f[13] * 16 + f[15] * 8 + f[16] * 4
      + (f[13] & f[14]) * 2 + (f[4] & f[5]);
    if (interrupt_reason_i == fprs_pkg::REASON_INVALID) begin
      a = 128;
      b = 0;
      c = 0;
    end
    exp_q = {a, b, c};
  endfunction

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    give_verdict();
  end

  initial begin
    repeat (6) @(negedge ref_clk_i);
    reset_i = 1'b0;
    check({4'h0, irq_o, result_phase_o, power_down_o, step_o}, 8'h00);
    i_fprs_host.read_port(3'h5, rd);
    check(rd, 8'h00);
    i_fprs_host.read_port(3'h3, rd);
    check(rd, 8'h00);
    $display("closed port test done");
    idle_i = 1'b1;
    for (n = 0; n < 200 && irq_o !== 1'b1; n++) @(negedge ref_clk_i);
    idle_i = 1'b0;
    check({4'h0, drive_ready_o}, 8'h0f);
    for (int d = 0; d < 4; d++) begin
      i_fprs_host.sense_query(rd);
      check(rd, 8'hc0 + 8'(d));
    end
    check({7'h0, irq_o}, 8'h00);
    i_fprs_host.sense_query(rd);
    check(rd, 8'h80);
    $display("ready change test done");
    idle_i = 1'b1;
    data_rate_i = fprs_pkg::RATE_300K;
    next_poll(g);
    n = 0;
    for (int j = 0; j < 3; j++) begin
      next_poll(g);
      n += g;
    end
    // Three periods at 300 Kbps span exactly five periods at 500 Kbps.
    check(8'(n), 8'(POLL_CYCLES * 5));
    for (int k = 0; k < 3; k++) begin
      data_rate_i = rates[k];
      next_poll(g);
      next_poll(g);
      next_poll(g);
      check(8'(g), 8'(gaps[k]));
    end
    $display("poll period test done");
    i_fprs_host.set_poll_disable(1'b1);
    r = rnd();
    step_dir_i = r[3:0];
    step_req_i = 4'h1 << r[5:4];
    for (n = 0; n < 200 && step_o !== 1'b1; n++) @(negedge ref_clk_i);
    check({7'h0, dir_o}, {7'h0, |(step_dir_i & step_req_i)});
    for (n = 0; n < 20 && step_o === 1'b1; n++) @(negedge ref_clk_i);
    check(8'(n), 8'(STEP_CYCLES));
    for (n = 0; n < 3 && step_ack_o !== step_req_i; n++) @(negedge ref_clk_i);
    check({4'h0, step_ack_o}, {4'h0, step_req_i});
    step_req_i = 4'h0;
    next_poll(g);
    cmd_start_i = 1'b1;
    @(negedge ref_clk_i);
    cmd_start_i = 1'b0;
    check({7'h0, param_hold_o}, 8'h01);
    for (n = 0; n < 20 && poll_active_o === 1'b1; n++) @(negedge ref_clk_i);
    check({7'h0, param_hold_o}, 8'h00);
    i_fprs_host.read_port(fprs_pkg::MAIN_STATE_OFFSET, rd);
    check({7'h0, rd[7]}, 8'h01);
    $display("step and hold test done");
    auto_pd_en_i = 1'b1;
    motor_off_expired_i = 1'b1;
    for (n = 0; n < 400 && power_down_o !== 1'b1; n++) @(negedge ref_clk_i);
    check(8'(n >= PDN_WAIT_CYCLES && n <= PDN_WAIT_CYCLES + POLL_CYCLES + 8), 8'h01);
    motor_off_expired_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check({7'h0, power_down_o}, 8'h00);
    $display("power-down test done");
    // A second reset with polling already disabled must raise no ready change.
    reset_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (100) @(negedge ref_clk_i);
    check({3'h0, irq_o, drive_ready_o}, 8'h00);
    $display("disabled poll reset test done");
    idle_i = 1'b0;
    for (int k = 0; k < 12; k++) begin
      interrupt_reason_i = k[1:0];
      r = rnd();
      {drive_sel_i, f} = r[19:0];
      f[2] = f[2] | f[1];
      model();
      term_i = 1'b1;
      @(negedge ref_clk_i);
      term_i = 1'b0;
      f = ~f;
      drive_sel_i = ~drive_sel_i;
      for (int j = 0; j < 3; j++) begin
        i_fprs_host.read_port(fprs_pkg::DATA_PORT_OFFSET, rd);
        check(rd, 8'(exp_q.pop_front()));
      end
      check({7'h0, result_phase_o}, 8'h00);
    end
    $display("status byte test done");
    give_verdict();
  end
endmodule

bind fprs_core fprs_core_chk #(.PDN_WAIT_CYCLES(PDN_WAIT_CYCLES),
  .STEP_CYCLES(STEP_CYCLES)) i_fprs_core_chk (.*);
